// File: plk_defs.svh
// Function
// [R01] Every received packet byte goes to the link, whatever its speed.
// [R02] Node speed alters only the self-ID speed code; peers always see S400.
// [R03] Node speed holds S400 after power-on; software rarely changes it.
// [R04] Leaf-only builds should write node speed right after any hardware reset.
// [R05] Reset input must stay low at least 2 ms after supply is valid.
// [R06] Register 1 trigger write starts bus reset, and also loads holdoff and gap.
// [R07] Sent or received configuration packets load holdoff flag and gap count.
// [R08] Two bus resets without a gap update between force gap count to 63.
// [R09] After sending a config packet, software starts a bus reset with matching values.
// [R10] Other trigger writes carry gap 63 and keep the current holdoff flag.
// [R11] Register 1 is written only together with the trigger bit set.
// [R12] Device supplies the interface clock; both sides drive and sample on its rise. The link model samples device pins on the fall.
// [R13] S100 uses lanes 0-1, S200 lanes 0-3, S400 all eight lanes.
// [R14] Device drives unused upper lanes low at S100 and S200.
// [R15] Device ignores unused lanes while the link drives the data bus.
// [R16] Link uses the serial request line for access, register and acceleration requests.
// [R17] Link reports power on its status line; device may stop clock or reset interface.
// [R18] Wake line carries wake-up, and interrupt when power status or control bit is low.
// [R19] Isolation select enables output differentiation on control pair and data lanes.
// [R20] Device drives control pair and lanes by default; link only after a grant.
// [R21] Exchanges are service request, status transfer, transmit and receive.
// [R22] Control codes: device idle/status/receive/grant, link release/hold/transmit.
// [R23] Differentiated outputs drive one clock per change, else float.
// [R24] Requests start with 1, end with 0, type in bits 1-3 MSB first.
// [R25] Node speed resets to S400; 00 S100, 01 S200, 11 illegal; bus reset keeps it.
//
// Purpose: constants of the link-facing port
// Assumes: 100 MHz block clock
// Notes:   offsets are Avalon byte addresses
`ifndef PLK_DEFS_SVH
`define PLK_DEFS_SVH
`define PLK_CLK_PS       10000
`define PLK_IFC_HALF_PS  10173
`define PLK_IFC_HALF     (`PLK_IFC_HALF_PS / `PLK_CLK_PS)
`define PLK_A_R1         4'h0
`define PLK_A_SPD        4'h4
`define PLK_A_STS        4'h8
`define PLK_R1_TRIG      6
`define PLK_R1_RHB       7
`define PLK_SPD_LINK_CONTROL_BIT    2
`define PLK_S100         2'b00
`define PLK_S200         2'b01
`define PLK_S400         2'b10
`define PLK_SILL         2'b11
`define PLK_GAP_MAX      6'h3f
`define PLK_RST_GAP      6'h3f
`define PLK_RST_RHB      1'b0
`define PLK_RST_LINK_CONTROL_BIT    1'b1
`define PLK_C_IDLE       2'b00
`define PLK_C_STAT       2'b01
`define PLK_C_RECV       2'b10
`define PLK_C_GRANT      2'b11
`define PLK_C_HOLD       2'b01
`define PLK_C_XMIT       2'b10
`define PLK_T_RD         3'b100
`define PLK_T_WR         3'b101
`define PLK_LEN_B7       5'd7
`define PLK_LEN_B8       5'd8
`define PLK_LEN_RD       5'd9
`define PLK_LEN_WR       5'd17
`define PLK_LEN_ACC      5'd6
`define PLK_LR_R1        4'h1
`define PLK_ST_TICKS     3'd7
`endif

// File: plk_pkg.sv
// Purpose: shared types of the link-facing port
// Assumes: nothing
// Notes:   constants live in plk_defs.svh
package plk_pkg;
	typedef enum logic [2:0] {PLK_IDLE, PLK_STAT, PLK_RECV, PLK_GRANT, PLK_LINK} plk_state_e;
	typedef logic [1:0] plk_speed_t;
endpackage : plk_pkg

// File: plk_diff_cell.sv
// Purpose: output enable of one pin, with optional differentiation
// Assumes: level changes only at tick edges
// Notes:   oe_n low means the pin is driven
`timescale 1ns/1ps
module plk_diff_cell
	import plk_pkg::*;
(
	// Clock and reset
	input  wire logic ref_clk_in,
	input  wire logic arst_n_in,
	// Control
	input  wire logic tick_in,
	input  wire logic level_in,
	input  wire logic own_in,
	input  wire logic diff_en_in,
	// Pin enable
	output logic      oe_n_out
);
	logic prev;

	always_ff @(posedge ref_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			prev <= 1'b0;
		else if (tick_in)
			prev <= level_in;
	end

	// Drive one interface period per change, float while constant
	assign oe_n_out = ~(own_in & (~diff_en_in | (level_in != prev))); // [R23]

	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!arst_n_in);
	a_diff_floats: assert property (diff_en_in && own_in && tick_in && level_in != prev // [R23]
		|=> oe_n_out || !diff_en_in || !own_in || $changed(level_in))
		else $error("differentiated pin driven while level constant");
endmodule : plk_diff_cell

// File: plk_link_port.sv
// Purpose: device end of the parallel link interface and bus reset logic
// Assumes: link pins asynchronous to ref_clk_in; core side on ref_clk_in
// Notes:   register 1 updates: config packet over link write over Avalon
//
// The register offsets and register access over Avalon-MM were decided locally.
`timescale 1ns/1ps
`include "plk_defs.svh"
module plk_link_port
	import plk_pkg::*;
(
	// Clock and reset
	input  wire logic        ref_clk_in,
	input  wire logic        arst_n_in,
	// Avalon-MM slave
	input  wire logic [3:0]  avs_address_in,
	input  wire logic        avs_read_in,
	input  wire logic        avs_write_in,
	input  wire logic [31:0] avs_writedata_in,
	output logic      [31:0] avs_readdata_out,
	output logic             avs_waitrequest_out,
	// Link pins
	output logic             interface_clock_out,
	input  wire logic [1:0]  control_pair_in,
	output logic      [1:0]  control_pair_out,
	output logic      [1:0]  control_pair_oe_n_out,
	input  wire logic [7:0]  data_lanes_in,
	output logic      [7:0]  data_lanes_out,
	output logic      [7:0]  data_lanes_oe_n_out,
	input  wire logic        serial_request_line_in,
	input  wire logic        link_power_status_in,
	input  wire logic        iso_n_in,
	output logic             wake_notify_line_out,
	// Core: receive stream
	input  wire logic        rx_valid_in,
	input  wire logic [7:0]  rx_data_in,
	input  wire logic [1:0]  rx_speed_in,
	output logic             rx_ready_out,
	// Core: transmit stream
	input  wire logic        grant_in,
	input  wire logic [1:0]  tx_speed_in,
	output logic             tx_valid_out,
	output logic      [7:0]  tx_data_out,
	// Core: service requests
	output logic             req_valid_out,
	output logic      [2:0]  req_type_out,
	output logic      [16:0] req_bits_out,
	// Core: configuration and bus reset
	input  wire logic        cfg_load_in,
	input  wire logic        cfg_rhb_in,
	input  wire logic [5:0]  cfg_gap_in,
	input  wire logic        bus_reset_in,
	output logic             bus_reset_req_out,
	output logic      [5:0]  gap_count_out,
	output logic             root_holdoff_flag_out,
	output logic      [1:0]  selfid_speed_out,
	output logic      [1:0]  peer_speed_out,
	// Core: power events
	input  wire logic        wake_req_in,
	input  wire logic        phy_irq_in
);
	// ------------------------------------------------------------
	// Decode helpers
	// ------------------------------------------------------------
	function automatic logic [7:0] spd_mask(input plk_speed_t s);
		spd_mask = (s == `PLK_S100) ? 8'h03 : (s == `PLK_S200) ? 8'h0f : 8'hff; // [R13]
	endfunction : spd_mask

	function automatic logic [4:0] req_len(input logic [2:0] t);
		req_len = (t == `PLK_T_RD) ? `PLK_LEN_RD : (t == `PLK_T_WR) ? `PLK_LEN_WR
			: `PLK_LEN_ACC;
	endfunction : req_len

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	localparam int NP = 13;
	logic [NP-1:0] pin_raw;
	logic [NP-1:0] pin_s1;
	logic [NP-1:0] pin_s;
	assign pin_raw = {iso_n_in, link_power_status_in, serial_request_line_in,
		data_lanes_in, control_pair_in};
	genvar gi;
	generate
		for (gi = 0; gi < NP; gi++)
		begin : g_sync
			always_ff @(posedge ref_clk_in or negedge arst_n_in)
			begin
				if (!arst_n_in)
				begin
					pin_s1[gi] <= 1'b0;
					pin_s[gi]  <= 1'b0;
				end
				else
				begin
					pin_s1[gi] <= pin_raw[gi];
					pin_s[gi]  <= pin_s1[gi];
				end
			end
		end
	endgenerate
	wire [1:0] ctl_s  = pin_s[1:0];
	wire [7:0] dat_s  = pin_s[9:2];
	wire       serial_request_line_s = pin_s[10];
	wire       lps_s  = pin_s[11];
	wire       iso_s  = pin_s[12];

	// ------------------------------------------------------------
	// Interface clock divider
	// ------------------------------------------------------------
	// 49.152 MHz cannot be hit from 100 MHz; nearest whole half period is used
	logic [3:0] hcnt;
	logic       ifc_clk;
	wire        hwrap = (hcnt == 4'((`PLK_IFC_HALF) - 1));
	wire        tick  = hwrap & ~ifc_clk & lps_s; // [R12]
	always_ff @(posedge ref_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			hcnt    <= 4'h0;
			ifc_clk <= 1'b0;
		end
		else if (!lps_s)
		begin
			hcnt    <= 4'h0;
			ifc_clk <= 1'b0; // [R17]
		end
		else
		begin
			hcnt    <= hwrap ? 4'h0 : hcnt + 4'h1;
			ifc_clk <= hwrap ? ~ifc_clk : ifc_clk;
		end
	end
	assign interface_clock_out = ifc_clk;

	// ------------------------------------------------------------
	// Serial request receiver
	// ------------------------------------------------------------
	logic        rq_busy;
	logic [4:0]  rq_cnt;
	logic [15:0] rq_sh;
	logic [2:0]  rq_typ;
	wire  [4:0]  rq_nb   = rq_cnt + 5'd1;
	wire  [16:0] rq_full = {rq_sh, serial_request_line_s};
	wire         rq_bus  = ~rq_typ[2];
	wire         rq_end  = rq_bus ? ((rq_nb == `PLK_LEN_B7 && !serial_request_line_s) || rq_nb == `PLK_LEN_B8)
		: (rq_nb == req_len(rq_typ));
	wire         rq_done = tick & rq_busy & (rq_cnt > 5'd3) & rq_end; // [R24]
	always_ff @(posedge ref_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			rq_busy <= 1'b0;
			rq_cnt  <= 5'd0;
			rq_sh   <= 16'h0000;
			rq_typ  <= 3'b000;
		end
		else if (tick)
		begin
			rq_busy <= rq_busy ? ~rq_done : serial_request_line_s; // [R16]
			rq_cnt  <= rq_busy ? rq_nb : 5'd1;
			rq_sh   <= rq_busy ? rq_full[15:0] : {15'h0000, serial_request_line_s};
			if (rq_busy && rq_cnt == 5'd3)
				rq_typ <= rq_full[2:0];
		end
	end
	always_ff @(posedge ref_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			req_valid_out <= 1'b0;
			req_type_out  <= 3'b000;
			req_bits_out  <= 17'h0_0000;
		end
		else
		begin
			req_valid_out <= rq_done;
			if (rq_done)
			begin
				req_type_out <= rq_typ;
				req_bits_out <= rq_full;
			end
		end
	end
	wire       lk_wr   = rq_done & (rq_typ == `PLK_T_WR);
	wire       lk_rd   = rq_done & (rq_typ == `PLK_T_RD);
	wire [3:0] lk_addr = (rq_typ == `PLK_T_WR) ? rq_full[12:9] : rq_full[4:1];
	wire       lk_r1   = lk_wr & (lk_addr == `PLK_LR_R1);

	// ------------------------------------------------------------
	// Avalon slave
	// ------------------------------------------------------------
	logic ack;
	wire  av_req = avs_read_in | avs_write_in;
	wire  av_wr  = avs_write_in & ack;
	wire  av_r1  = av_wr & (avs_address_in == `PLK_A_R1);
	wire  av_spd = av_wr & (avs_address_in == `PLK_A_SPD);
	assign avs_waitrequest_out = av_req & ~ack;
	always_ff @(posedge ref_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			ack <= 1'b0;
		else
			ack <= av_req & ~ack;
	end

	// ------------------------------------------------------------
	// Register 1: trigger, holdoff flag, gap count
	// ------------------------------------------------------------
	logic       root_holdoff_flag;
	logic [5:0] gap;
	logic       upd_since;
	logic       rst_seen;
	logic [3:0] rst_cnt;
	wire        upd      = cfg_load_in | lk_r1 | av_r1; // [R06] [R07]
	wire        next_rhb = cfg_load_in ? cfg_rhb_in : lk_r1 ? rq_full[8]
		: avs_writedata_in[`PLK_R1_RHB];
	wire  [5:0] next_gap = cfg_load_in ? cfg_gap_in : lk_r1 ? rq_full[6:1]
		: avs_writedata_in[5:0];
	wire        trig     = (lk_r1 & rq_full[7]) | (av_r1 & avs_writedata_in[`PLK_R1_TRIG]);
	wire        force63  = bus_reset_in & rst_seen & ~upd_since & ~upd;
	always_ff @(posedge ref_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			root_holdoff_flag <= `PLK_RST_RHB;
			gap <= `PLK_RST_GAP;
		end
		else if (upd)
		begin
			root_holdoff_flag <= next_rhb; // [R06] [R07]
			gap <= next_gap;
		end
		else if (force63)
			gap <= `PLK_GAP_MAX; // [R08]
	end
	// An update in the reset's own cycle counts as following it
	always_ff @(posedge ref_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			upd_since         <= 1'b0;
			rst_seen          <= 1'b0;
			rst_cnt           <= 4'h0;
			bus_reset_req_out <= 1'b0;
		end
		else
		begin
			upd_since         <= upd | (upd_since & ~bus_reset_in); // [R08]
			rst_seen          <= rst_seen | bus_reset_in;
			rst_cnt           <= rst_cnt + {3'b000, bus_reset_in};
			bus_reset_req_out <= trig; // [R06]
		end
	end
	assign gap_count_out         = gap;
	assign root_holdoff_flag_out = root_holdoff_flag;

	// ------------------------------------------------------------
	// Node speed and link control bit
	// ------------------------------------------------------------
	plk_speed_t node_spd;
	logic       link_control_bit;
	wire        spd_ok = avs_writedata_in[1:0] != `PLK_SILL; // [R25]
	always_ff @(posedge ref_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			node_spd <= `PLK_S400; // [R03] [R25]
			link_control_bit    <= `PLK_RST_LINK_CONTROL_BIT;
		end
		else if (av_spd)
		begin
			node_spd <= spd_ok ? avs_writedata_in[1:0] : node_spd;
			link_control_bit    <= avs_writedata_in[`PLK_SPD_LINK_CONTROL_BIT];
		end
	end
	assign selfid_speed_out = node_spd; // [R02]
	assign peer_speed_out   = `PLK_S400; // [R02]

	// ------------------------------------------------------------
	// Avalon read data
	// ------------------------------------------------------------
	plk_state_e st;
	wire [31:0] rd_r1  = {24'h00_0000, root_holdoff_flag, 1'b0, gap};
	wire [31:0] rd_spd = {29'h0000_0000, link_control_bit, node_spd};
	wire [31:0] rd_sts = {24'h00_0000, rst_cnt, upd_since, st == PLK_LINK, iso_s, lps_s};
	wire [31:0] next_rd = (avs_address_in == `PLK_A_R1) ? rd_r1
		: (avs_address_in == `PLK_A_SPD) ? rd_spd
		: (avs_address_in == `PLK_A_STS) ? rd_sts : 32'h0000_0000;
	always_ff @(posedge ref_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			avs_readdata_out <= 32'h0000_0000;
		else if (avs_read_in && !ack)
			avs_readdata_out <= next_rd;
	end

	// ------------------------------------------------------------
	// Control pair sequencer
	// ------------------------------------------------------------
	logic        grant_pend;
	logic        st_pend;
	logic [15:0] st_sh;
	logic [2:0]  st_cnt;
	logic [1:0]  ctl_q;
	logic [7:0]  dat_q;
	logic        own;
	plk_speed_t  tx_spd;
	wire  [15:0] st_word = {4'h0, lk_addr, (lk_addr == `PLK_LR_R1) ? rd_r1[7:0] : 8'h00};
	wire         rx_go   = tick & rx_valid_in & (st == PLK_IDLE | st == PLK_RECV);
	assign rx_ready_out = rx_go; // [R01]
	// Set wins over clear for both pending flags
	always_ff @(posedge ref_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			grant_pend <= 1'b0;
			st_pend    <= 1'b0;
			st_sh      <= 16'h0000;
		end
		else
		begin
			grant_pend <= grant_in | (grant_pend & ~(st == PLK_GRANT));
			st_pend    <= lk_rd | (st_pend & ~(tick & st == PLK_STAT & st_cnt == 3'd0));
			if (lk_rd)
				st_sh <= st_word;
			else if (tick && st == PLK_STAT)
				st_sh <= {st_sh[13:0], 2'b00};
		end
	end
	always_ff @(posedge ref_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			st     <= PLK_IDLE;
			ctl_q  <= `PLK_C_IDLE;
			dat_q  <= 8'h00;
			own    <= 1'b1;
			st_cnt <= 3'd0;
			tx_spd <= `PLK_S100;
		end
		else if (!lps_s)
		begin
			st    <= PLK_IDLE; // [R17]
			ctl_q <= `PLK_C_IDLE;
			dat_q <= 8'h00;
			own   <= 1'b1;
		end
		else if (tick)
		begin
			case (st)
				PLK_IDLE, PLK_RECV:
				begin
					own <= 1'b1; // [R20]
					if (rx_valid_in)
					begin
						st    <= PLK_RECV;
						ctl_q <= `PLK_C_RECV; // [R22]
						dat_q <= rx_data_in & spd_mask(rx_speed_in); // [R01] [R14]
					end
					else if (grant_pend)
					begin
						st     <= PLK_GRANT;
						ctl_q  <= `PLK_C_GRANT;
						dat_q  <= 8'h00;
						tx_spd <= tx_speed_in;
					end
					else if (st_pend)
					begin
						st     <= PLK_STAT;
						ctl_q  <= `PLK_C_STAT; // [R21]
						dat_q  <= {6'h00, st_sh[14], st_sh[15]};
						st_cnt <= `PLK_ST_TICKS;
					end
					else
					begin
						st    <= PLK_IDLE;
						ctl_q <= `PLK_C_IDLE;
						dat_q <= 8'h00;
					end
				end
				PLK_STAT:
				begin
					st_cnt <= st_cnt - 3'd1;
					st     <= (st_cnt == 3'd0) ? PLK_IDLE : PLK_STAT;
					ctl_q  <= (st_cnt == 3'd0) ? `PLK_C_IDLE : `PLK_C_STAT;
					dat_q  <= (st_cnt == 3'd0) ? 8'h00 : {6'h00, st_sh[12], st_sh[13]};
				end
				PLK_GRANT:
				begin
					st    <= PLK_LINK;
					ctl_q <= `PLK_C_IDLE;
					own   <= 1'b0; // [R20]
				end
				PLK_LINK:
					if (ctl_s == `PLK_C_IDLE)
					begin
						st  <= PLK_IDLE;
						own <= 1'b1;
					end
				default:
					st <= PLK_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Transmit capture
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			tx_valid_out <= 1'b0;
			tx_data_out  <= 8'h00;
		end
		else
		begin
			tx_valid_out <= tick & (st == PLK_LINK) & (ctl_s == `PLK_C_XMIT);
			if (tick && st == PLK_LINK && ctl_s == `PLK_C_XMIT)
				tx_data_out <= dat_s & spd_mask(tx_spd); // [R15]
		end
	end

	// ------------------------------------------------------------
	// Pin drivers and wake line
	// ------------------------------------------------------------
	assign control_pair_out = ctl_q;
	assign data_lanes_out   = dat_q;
	wire [9:0] drv_lvl = {dat_q, ctl_q};
	wire [9:0] drv_oe_n;
	generate
		for (gi = 0; gi < 10; gi++)
		begin : g_drv
			plk_diff_cell u_cell (
				.ref_clk_in (ref_clk_in),
				.arst_n_in  (arst_n_in),
				.tick_in    (tick),
				.level_in   (drv_lvl[gi]),
				.own_in     (own),
				.diff_en_in (~iso_s), // [R19]
				.oe_n_out   (drv_oe_n[gi])
			);
		end
	endgenerate
	assign control_pair_oe_n_out = drv_oe_n[1:0];
	assign data_lanes_oe_n_out   = drv_oe_n[9:2];
	always_ff @(posedge ref_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			wake_notify_line_out <= 1'b0;
		else
			wake_notify_line_out <= wake_req_in | (phy_irq_in & (~lps_s | ~link_control_bit)); // [R18]
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!arst_n_in);
	a_gap_forced_63: assert property (force63 |=> gap == `PLK_GAP_MAX) // [R08]
		else $error("gap not forced to 63");
	a_cfg_loads_reg: assert property (cfg_load_in |=> gap == $past(cfg_gap_in) // [R07]
		&& root_holdoff_flag == $past(cfg_rhb_in))
		else $error("config packet not loaded");
	a_trigger_reset: assert property (trig |=> bus_reset_req_out ##1 !bus_reset_req_out) // [R06]
		else $error("trigger write gave no bus reset pulse");
	a_speed_kept: assert property (bus_reset_in && !av_spd |=> $stable(node_spd)) // [R25]
		else $error("bus reset changed node speed");
	a_speed_legal: assert property (node_spd != `PLK_SILL) // [R25]
		else $error("illegal node speed stored");
	a_upper_low: assert property (rx_go |=> (dat_q & ~spd_mask($past(rx_speed_in))) == 8'h00) // [R14]
		else $error("unused lanes not low");
	a_rx_forward: assert property (rx_go |=> ctl_q == `PLK_C_RECV) // [R01]
		else $error("received byte not forwarded");
	a_tx_masked: assert property (tx_valid_out |-> (tx_data_out & ~spd_mask(tx_spd)) == 8'h00) // [R15]
		else $error("unused transmit lanes kept");
	a_link_owns: assert property (st == PLK_LINK |-> &drv_oe_n) // [R20]
		else $error("device drives bus while link owns it");
	a_grant_handoff: assert property (tick && st == PLK_GRANT |=> st == PLK_LINK && !own) // [R20]
		else $error("grant not followed by handoff");
	a_wait_one: assert property (av_req && avs_waitrequest_out |=> !avs_waitrequest_out)
		else $error("waitrequest held beyond one cycle");
	c_receive: cover property (rx_go ##1 rx_go);
	c_grant: cover property (st == PLK_GRANT ##[1:20] tx_valid_out);
	c_status: cover property (lk_rd ##[1:60] st == PLK_STAT);
	c_force63: cover property (force63);
endmodule : plk_link_port

// File: plk_link_model.sv
// Purpose: behavioural link controller on the far side of the port
// Assumes: samples device pins on the interface clock fall, drives on its rise
// Notes:   shared pin resolution is done by the bench
`timescale 1ns/1ps
module plk_link_model
(
	// Interface clock and device control seen
	input  wire logic        ifc_in,
	input  wire logic [1:0]  ctl_in,
	// Request command from the bench
	input  wire logic        send_in,
	input  wire logic [16:0] bits_in,
	input  wire logic [4:0]  len_in,
	// Pins driven by the link
	output logic             serial_request_line_out,
	output logic             drive_out,
	output logic      [1:0]  ctl_out,
	output logic      [7:0]  data_out,
	output logic             lps_out
);
	logic granted;
	logic sent;
	initial
	begin
		serial_request_line_out  = 1'b0;
		drive_out = 1'b0;
		ctl_out   = 2'b00;
		data_out  = 8'h00;
		lps_out   = 1'b1;
		granted   = 1'b0;
		sent      = 1'b0;
	end
	// Sampling on the fall keeps clear of the tick edge where outputs move
	always @(negedge ifc_in)
		granted <= (ctl_in == 2'b11) && !drive_out;
	always @(posedge ifc_in)
	begin
		if (granted)
		begin
			drive_out <= 1'b1;
			ctl_out   <= 2'b10;
			data_out  <= 8'hff;
			repeat (2) @(posedge ifc_in);
			ctl_out <= 2'b00;
			@(posedge ifc_in);
			drive_out <= 1'b0;
		end
	end
	// One stream per raised command, MSB first, line idles low
	always @(posedge ifc_in)
	begin
		if (send_in && !sent)
		begin
			for (int i = 16; i >= 0; i--)
			begin
				if (i < len_in)
				begin
					serial_request_line_out <= bits_in[i];
					@(posedge ifc_in);
				end
			end
			serial_request_line_out <= 1'b0;
			sent = 1'b1;
		end
		if (!send_in)
			sent = 1'b0;
	end
endmodule : plk_link_model

// File: test_plk_link_port.sv
// Purpose: self-checking bench of the link-facing port
// Assumes: Avalon answers after waitrequest drops
// Notes:   pulses are counted at the falling edge where they are settled
`timescale 1ns/1ps
`include "plk_defs.svh"
module test_plk_link_port
	import plk_pkg::*;
;
	logic clk, rst_n, rd, wr, ifc, serial_request_line, link_power_status, iso_n, wake, rx_v, rx_r, grant, tx_v;
	logic req_v, cfg, cfg_rhb, brst, br_req, root_holdoff_flag, wake_req, irq, m_drv, send, wait_r;
	logic [1:0] ctl_o, ctl_oe, rx_s, tx_s, sid, peer, m_ctl;
	logic [7:0] d_o, d_oe, rx_d, tx_d, m_d, tx_seen, rx_exp, rx_mask;
	logic [3:0] addr;
	logic [31:0] wdata, rdata, q;
	logic [2:0] req_t;
	logic [16:0] req_b, lr_bits;
	logic [15:0] st_seen;
	logic [4:0] lr_len;
	logic [5:0] gap, cfg_gap;
	int mismatches, checked, n_br, n_tx, n_req, n_st, hit, bad;
	wire [1:0] ctl_in = m_drv ? m_ctl : ctl_o;
	wire [7:0] d_in = m_drv ? m_d : d_o;
	plk_link_port DUT (.ref_clk_in(clk), .arst_n_in(rst_n), .avs_address_in(addr),
		.avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
		.avs_readdata_out(rdata), .avs_waitrequest_out(wait_r), .interface_clock_out(ifc),
		.control_pair_in(ctl_in), .control_pair_out(ctl_o), .control_pair_oe_n_out(ctl_oe),
		.data_lanes_in(d_in), .data_lanes_out(d_o), .data_lanes_oe_n_out(d_oe),
		.serial_request_line_in(serial_request_line), .link_power_status_in(link_power_status), .iso_n_in(iso_n),
		.wake_notify_line_out(wake), .rx_valid_in(rx_v), .rx_data_in(rx_d),
		.rx_speed_in(rx_s), .rx_ready_out(rx_r), .grant_in(grant), .tx_speed_in(tx_s),
		.tx_valid_out(tx_v), .tx_data_out(tx_d), .req_valid_out(req_v),
		.req_type_out(req_t), .req_bits_out(req_b), .cfg_load_in(cfg), .cfg_rhb_in(cfg_rhb),
		.cfg_gap_in(cfg_gap), .bus_reset_in(brst), .bus_reset_req_out(br_req),
		.gap_count_out(gap), .root_holdoff_flag_out(root_holdoff_flag), .selfid_speed_out(sid),
		.peer_speed_out(peer), .wake_req_in(wake_req), .phy_irq_in(irq));
	plk_link_model LINK (.ifc_in(ifc), .ctl_in(ctl_o), .send_in(send), .bits_in(lr_bits),
		.len_in(lr_len), .serial_request_line_out(serial_request_line), .drive_out(m_drv), .ctl_out(m_ctl),
		.data_out(m_d), .lps_out(link_power_status));
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(negedge clk)
	begin
		n_br  += (br_req === 1'b1);
		n_req += (req_v === 1'b1);
		if (tx_v === 1'b1)
		begin
			n_tx++;
			tx_seen = tx_d;
		end
		if (ctl_o === `PLK_C_STAT && ifc === 1'b1)
		begin
			n_st++;
			st_seen = {st_seen[13:0], d_o[0], d_o[1]};
		end
		if (ctl_o === `PLK_C_RECV)
		begin
			hit += (d_o === rx_exp);
			bad += ((d_o & ~rx_mask) !== 8'h00);
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= w;
		rd    <= !w;
		do @(posedge clk); while (wait_r !== 1'b0);
		q = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
		repeat (4) @(posedge clk);
	endtask : av
	task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
		av(1'b0, a, 32'h0000_0000);
		check(q, exp);
	endtask : rd_chk
	task automatic br_pulse;
		@(posedge clk);
		brst <= 1'b1;
		@(posedge clk);
		brst <= 1'b0;
		repeat (4) @(posedge clk);
	endtask : br_pulse
	task automatic rx(input logic [1:0] s, input logic [7:0] v, input logic [7:0] m);
		hit     = 0;
		bad     = 0;
		rx_exp  = v & m;
		rx_mask = m;
		@(posedge clk);
		rx_v <= 1'b1;
		rx_d <= v;
		rx_s <= s;
		do @(posedge clk); while (rx_r !== 1'b1);
		rx_v <= 1'b0;
		repeat (60) @(posedge clk);
	endtask : rx
	task automatic results;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : results
	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial
	begin
		{rst_n, rd, wr, rx_v, grant, cfg, cfg_rhb, brst, wake_req, irq, send} = 0;
		{addr, wdata, rx_d, rx_s, tx_s, cfg_gap} = 0;
		iso_n = 1'b1;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		repeat (10) @(posedge clk);
		rd_chk(4'h0, 32'h0000_003f);
		rd_chk(4'h4, 32'h0000_0006);
		rd_chk(4'h8, 32'h0000_0003);
		rd_chk(4'hc, 32'h0000_0000);
		check(peer, `PLK_S400);
		av(1'b1, 4'h4, 32'h0000_0004);
		check(sid, `PLK_S100);
		check(peer, `PLK_S400);
		av(1'b1, 4'h4, 32'h0000_0007);
		check(sid, `PLK_S100);
		irq <= 1'b1;
		av(1'b1, 4'h4, 32'h0000_0006);
		check(wake, 1'b0);
		av(1'b1, 4'h4, 32'h0000_0002);
		check(wake, 1'b1);
		av(1'b1, 4'h4, 32'h0000_0006);
		irq      <= 1'b0;
		wake_req <= 1'b1;
		repeat (4) @(posedge clk);
		check(wake, 1'b1);
		wake_req <= 1'b0;
		av(1'b1, 4'h0, 32'h0000_00c5);
		check(n_br, 1);
		check({root_holdoff_flag, gap}, 7'h45);
		rd_chk(4'h0, 32'h0000_0085);
		br_pulse();
		check(gap, 6'h05);
		br_pulse();
		check(gap, 6'h3f);
		@(posedge clk);
		{cfg, cfg_rhb, cfg_gap} <= {1'b1, 1'b0, 6'h0a};
		@(posedge clk);
		cfg <= 1'b0;
		br_pulse();
		check({root_holdoff_flag, gap}, 7'h0a);
		av(1'b1, 4'h0, 32'h0000_007f);
		check({root_holdoff_flag, gap}, 7'h3f);
		rx(`PLK_S100, 8'hff, 8'h03);
		check(bad, 0);
		check(hit != 0, 1);
		rx(`PLK_S200, 8'hff, 8'h0f);
		check(bad, 0);
		check(hit != 0, 1);
		rx(`PLK_S400, 8'ha5, 8'hff);
		check(hit != 0, 1);
		@(posedge clk);
		grant <= 1'b1;
		@(posedge clk);
		grant   <= 1'b0;
		lr_bits <= 17'h1_a28e;
		lr_len  <= 5'd17;
		repeat (100) @(posedge clk);
		check(n_tx != 0, 1);
		check(tx_seen, 8'h03);
		send <= 1'b1;
		repeat (200) @(posedge clk);
		send <= 1'b0;
		check(n_req, 1);
		check(req_t, `PLK_T_WR);
		check(req_b, 17'h1_a28e);
		check(gap, 6'h07);
		check(n_br, 3);
		check(d_oe, 8'h00);
		lr_bits <= 17'h0_0182;
		lr_len  <= 5'd9;
		repeat (4) @(posedge clk);
		send <= 1'b1;
		repeat (100) @(posedge clk);
		check(n_req, 2);
		check(req_t, `PLK_T_RD);
		check(n_st, 8);
		check(st_seen, 16'h0107);
		iso_n <= 1'b0;
		repeat (20) @(posedge clk);
		check({ctl_oe, d_oe}, 10'h3ff);
		results();
	end
	// A hang is cut short well past the expected run length
	initial
	begin
		#100000;
		mismatches++;
		results();
	end
endmodule : test_plk_link_port
